// >>> lvpm_cfg.svh
// Offsets, field positions, reset values and fixed codes of the supply
// supervisor and power mode control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LVPM_CFG_SVH
`define LVPM_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LVPM_OFS_DET 8'h00
`define LVPM_OFS_WARN 8'h04
`define LVPM_OFS_STAT 8'h08
`define LVPM_OFS_MASK 8'h0C

// ----------------------------------------------------------------------
// Detect control fields
// ----------------------------------------------------------------------
`define LVPM_DET_FLAG 7
`define LVPM_DET_ACK 6
`define LVPM_DET_IE 5
`define LVPM_DET_RE 4
`define LVPM_DET_SE 3
`define LVPM_DET_DE 2
`define LVPM_DET_ONCE_MASK 8'h1C
`define LVPM_DET_RST 8'h14

// ----------------------------------------------------------------------
// Warning and stop control fields
// ----------------------------------------------------------------------
`define LVPM_WRN_FLAG 7
`define LVPM_WRN_ACK 6
`define LVPM_WRN_DV 5
`define LVPM_WRN_WV 4
`define LVPM_WRN_PPD_FLAG 3
`define LVPM_WRN_PACK 2
`define LVPM_WRN_PD_EN 1
`define LVPM_WRN_PPD_SEL 0
`define LVPM_WRN_RST 8'h00

// ----------------------------------------------------------------------
// Event status and mask fields
// ----------------------------------------------------------------------
`define LVPM_EV_DET 0
`define LVPM_EV_WARN 1
`define LVPM_EV_PPD 2
`define LVPM_EV_RST 3'h0

`endif

// >>> lvpm_pkg.sv
// Types shared by the supply supervisor and power mode control block.
// Assumes lvpm_cfg.svh sits in the same folder.
package lvpm_pkg;
`include "lvpm_cfg.svh"

   // Register selected by a bus address
   typedef enum logic [2:0] {
      LVPM_SEL_DET,
      LVPM_SEL_WARN,
      LVPM_SEL_STAT,
      LVPM_SEL_MASK,
      LVPM_SEL_NONE
   } lvpm_sel_t;

endpackage

// >>> lvpm_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/10ps
module lvpm_sync import lvpm_pkg::*; #(
   parameter int WIDTH = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stage1 <= '0;
         o_sync <= '0;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end

endmodule

// >>> lvpm_ahb_slave.sv
// AHB-Lite slave front end: turns transfers into write and read strobes.
// Assumes single word transfers; reads take one wait state so that a
// write in the preceding data phase is visible to the read.
`timescale 1ns/10ps
module lvpm_ahb_slave import lvpm_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic [7:0] i_rdata,
   output logic o_hreadyout,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_addr,
   output logic [31:0] o_hrdata
);

   logic dp_wr;
   logic dp_rd;
   logic rd_pend;
   wire accept = i_hsel & i_hready & i_htrans[1];

   assign o_hreadyout = ~(dp_rd & rd_pend);
   assign o_wr_en = dp_wr;
   assign o_rd_en = dp_rd & rd_pend;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         rd_pend <= 1'b0;
         o_addr <= 8'h00;
      end else if (i_hready) begin
         dp_wr <= accept & i_hwrite;
         dp_rd <= accept & ~i_hwrite;
         rd_pend <= accept & ~i_hwrite;
         if (accept) begin
            o_addr <= i_haddr[7:0];
         end
      end else begin
         rd_pend <= 1'b0;
      end
   end

   // Read data latched at the end of the wait state
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hrdata <= 32'h00000000;
      end else if (o_rd_en) begin
         o_hrdata <= {24'h000000, i_rdata};
      end
   end

endmodule

// >>> lvpm_top.sv
// Supply supervisor and low-power mode control with AHB-Lite registers.
// Assumes trip comparators drive levels asynchronous to i_sys_clk, and the
// stop mode state and stop recovery pulse come from logic on i_sys_clk.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "lvpm_cfg.svh"
module lvpm_top import lvpm_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_por_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_lvd_trip_low,
   input wire logic i_lvd_trip_high,
   input wire logic i_lvw_trip_low,
   input wire logic i_lvw_trip_high,
   input wire logic i_stop_mode,
   input wire logic i_partial_powerdown_stop_exit,
   output logic o_lvd_comp_enable,
   output logic o_detect_threshold_select,
   output logic o_warning_threshold_select,
   output logic o_lvd_irq,
   output logic o_lvd_reset_req,
   output logic o_powerdown_enable,
   output logic o_partial_powerdown_select,
   output logic o_irq
);

   // -------------------------------------------------------------------
   // Reset combination
   // -------------------------------------------------------------------
   // A power-on reset is also a reset of every other bit
   wire rst_all_n = i_rstn & i_por_rstn;

   // -------------------------------------------------------------------
   // Bus front end
   // -------------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic [7:0] bus_addr;
   logic [7:0] rdata;

   lvpm_ahb_slave i_lvpm_ahb_slave (
      .i_sys_clk(i_sys_clk),
      .i_rstn(rst_all_n),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hready(i_hready),
      .i_rdata(rdata),
      .o_hreadyout(o_hreadyout),
      .o_wr_en(wr_en),
      .o_rd_en(rd_en),
      .o_addr(bus_addr),
      .o_hrdata(o_hrdata)
   );

   // Only OKAY responses; unmapped reads return zero
   assign o_hresp = 1'b0;

   // Only word transfers exist, so the size is not decoded
   wire [2:0] unused_size = i_hsize;
   wire [7:0] wbyte = i_hwdata[7:0];

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   function automatic lvpm_sel_t decode(input logic [7:0] addr);
      if (addr == `LVPM_OFS_DET) begin
         decode = LVPM_SEL_DET;
      end else if (addr == `LVPM_OFS_WARN) begin
         decode = LVPM_SEL_WARN;
      end else if (addr == `LVPM_OFS_STAT) begin
         decode = LVPM_SEL_STAT;
      end else if (addr == `LVPM_OFS_MASK) begin
         decode = LVPM_SEL_MASK;
      end else begin
         decode = LVPM_SEL_NONE;
      end
   endfunction

   wire lvpm_sel_t sel = decode(bus_addr);
   wire wr_det = wr_en & (sel == LVPM_SEL_DET);
   wire wr_warn = wr_en & (sel == LVPM_SEL_WARN);
   wire wr_mask = wr_en & (sel == LVPM_SEL_MASK);
   wire rd_stat = rd_en & (sel == LVPM_SEL_STAT);

   // -------------------------------------------------------------------
   // Comparator inputs
   // -------------------------------------------------------------------
   logic [3:0] trip_sync;

   lvpm_sync #(.WIDTH(4)) i_lvpm_sync (
      .i_sys_clk(i_sys_clk),
      .i_rstn(rst_all_n),
      .i_async({i_lvw_trip_high, i_lvw_trip_low,
                i_lvd_trip_high, i_lvd_trip_low}),
      .o_sync(trip_sync)
   );

   // -------------------------------------------------------------------
   // Control state
   // -------------------------------------------------------------------
   logic det_flag;
   logic irq_en;
   logic rst_en;
   logic stop_en;
   logic det_en;
   logic det_locked;
   logic warn_flag;
   logic det_thr;
   logic warn_thr;
   logic ppd_flag;
   logic pd_en;
   logic ppd_sel;
   logic pd_locked;
   logic [2:0] ev_stat;
   logic [2:0] ev_mask;

   // -------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------
   // A set in the same cycle as its clear wins, so no event is lost
   function automatic logic sticky(input logic hit, flag, clr);
      sticky = hit | (flag & ~clr);
   endfunction

   // Register bit update: the written value under a strobe, else kept
   function automatic logic field(input logic wr, wval, cur);
      if (wr) begin
         field = wval;
      end else begin
         field = cur;
      end
   endfunction

   // Status records the first cycle of a flag, not its level
   function automatic logic rise(input logic hit, flag);
      rise = hit & ~flag;
   endfunction

   // The select bit chooses which comparator the flag listens to
   function automatic logic pick_trip(input logic high, hi, lo);
      pick_trip = high ? hi : lo;
   endfunction

   // -------------------------------------------------------------------
   // Detection
   // -------------------------------------------------------------------
   // Trip choice follows the select bits
   wire det_below = pick_trip(det_thr, trip_sync[1], trip_sync[0]);
   wire warn_below = pick_trip(warn_thr, trip_sync[3], trip_sync[2]);

   // Detector runs when enabled, and in stop only if stop enable is set
   wire det_active = det_en & (~i_stop_mode | stop_en);

   // Level based, so a supply already low at enable is still caught
   wire det_set = det_active & det_below;
   wire det_clr = wr_det & wbyte[`LVPM_DET_ACK];
   wire next_det_flag = sticky(det_set, det_flag, det_clr);

   // Warning follows the supply level even straight after reset
   wire warn_set = warn_below;
   // Ack loses to a warning still present since the set wins
   wire warn_clr = wr_warn & wbyte[`LVPM_WRN_ACK];
   wire next_warn_flag = sticky(warn_set, warn_flag, warn_clr);

   wire ppd_set = i_partial_powerdown_stop_exit;
   wire ppd_clr = wr_warn & wbyte[`LVPM_WRN_PACK];
   wire next_ppd_flag = sticky(ppd_set, ppd_flag, ppd_clr);

   // -------------------------------------------------------------------
   // Write-once fields, and the interrupt enable taken on every detect write
   // -------------------------------------------------------------------
   wire det_once_wr = wr_det & ~det_locked;
   wire next_det_en = field(det_once_wr, wbyte[`LVPM_DET_DE], det_en);
   wire next_rst_en = field(det_once_wr, wbyte[`LVPM_DET_RE], rst_en);
   wire next_stop_en = field(det_once_wr, wbyte[`LVPM_DET_SE], stop_en);
   wire next_irq_en = field(wr_det, wbyte[`LVPM_DET_IE], irq_en);

   wire pd_once_wr = wr_warn & ~pd_locked;
   wire next_pd_en = field(pd_once_wr, wbyte[`LVPM_WRN_PD_EN], pd_en);
   wire next_ppd_sel = field(pd_once_wr, wbyte[`LVPM_WRN_PPD_SEL], ppd_sel);

   // -------------------------------------------------------------------
   // Event status, mask and interrupt
   // -------------------------------------------------------------------
   // Rising edges of the flags are the recorded events
   wire [2:0] ev_set = {rise(ppd_set, ppd_flag),
                        rise(warn_set, warn_flag),
                        rise(det_set, det_flag)};
   // A read clears, but an event in the same cycle survives it
   wire [2:0] next_ev_stat = ev_set | (ev_stat & {3{~rd_stat}});
   wire [2:0] next_ev_mask = wr_mask ? wbyte[2:0] : ev_mask;

   // -------------------------------------------------------------------
   // Registers loaded with their reset values by any reset
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge rst_all_n) begin
      if (!rst_all_n) begin
         det_flag <= 1'b0;
         irq_en <= 1'(`LVPM_DET_RST >> `LVPM_DET_IE);
         rst_en <= 1'(`LVPM_DET_RST >> `LVPM_DET_RE);
         stop_en <= 1'(`LVPM_DET_RST >> `LVPM_DET_SE);
         det_en <= 1'(`LVPM_DET_RST >> `LVPM_DET_DE);
         det_locked <= 1'b0;
      end else begin
         det_flag <= next_det_flag;
         irq_en <= next_irq_en;
         rst_en <= next_rst_en;
         stop_en <= next_stop_en;
         det_en <= next_det_en;
         det_locked <= det_locked | wr_det;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_all_n) begin
      if (!rst_all_n) begin
         warn_flag <= 1'b0;
         ppd_flag <= 1'b0;
         pd_en <= 1'b0;
         ppd_sel <= 1'b0;
         pd_locked <= 1'b0;
      end else begin
         warn_flag <= next_warn_flag;
         ppd_flag <= next_ppd_flag;
         pd_en <= next_pd_en;
         ppd_sel <= next_ppd_sel;
         pd_locked <= pd_locked | wr_warn;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_all_n) begin
      if (!rst_all_n) begin
         ev_stat <= `LVPM_EV_RST;
         ev_mask <= `LVPM_EV_RST;
      end else begin
         ev_stat <= next_ev_stat;
         ev_mask <= next_ev_mask;
      end
   end

   // -------------------------------------------------------------------
   // Threshold selects kept across all but power-on reset
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_por_rstn) begin
      if (!i_por_rstn) begin
         det_thr <= 1'b0;
         warn_thr <= 1'b0;
      end else if (wr_warn) begin
         det_thr <= wbyte[`LVPM_WRN_DV];
         warn_thr <= wbyte[`LVPM_WRN_WV];
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   // Acks and unimplemented bits read as zero
   wire [7:0] det_rd = {det_flag, 1'b0, irq_en, rst_en,
                        stop_en, det_en, 2'b00};
   wire [7:0] warn_rd = {warn_flag, 1'b0, det_thr, warn_thr,
                         ppd_flag, 1'b0, pd_en, ppd_sel};
   function automatic logic [7:0] read_mux(input lvpm_sel_t s,
      input logic [7:0] dv, wv, input logic [2:0] sv, mv);
      if (s == LVPM_SEL_DET) begin
         read_mux = dv;
      end else if (s == LVPM_SEL_WARN) begin
         read_mux = wv;
      end else if (s == LVPM_SEL_STAT) begin
         read_mux = {5'h00, sv};
      end else if (s == LVPM_SEL_MASK) begin
         read_mux = {5'h00, mv};
      end else begin
         read_mux = 8'h00;
      end
   endfunction

   assign rdata = read_mux(sel, det_rd, warn_rd, ev_stat, ev_mask);

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Terms use next values so each output moves in the same cycle as
   // the register bit behind it
   wire next_lvd_irq = next_det_flag & next_irq_en & next_det_en;
   wire next_lvd_reset_req = next_det_flag & next_rst_en
      & next_det_en;
   wire next_irq = |(next_ev_stat & next_ev_mask);
   wire next_comp_enable = next_det_en & (~i_stop_mode | next_stop_en);
   wire next_ppd_out = next_pd_en & next_ppd_sel;

   // Kept as flops so the reset request cannot glitch into the reset tree
   always_ff @(posedge i_sys_clk or negedge rst_all_n) begin
      if (!rst_all_n) begin
         o_lvd_irq <= 1'b0;
         o_lvd_reset_req <= 1'b0;
         o_irq <= 1'b0;
         o_lvd_comp_enable <= 1'b0;
         o_powerdown_enable <= 1'b0;
         o_partial_powerdown_select <= 1'b0;
      end else begin
         o_lvd_irq <= next_lvd_irq;
         o_lvd_reset_req <= next_lvd_reset_req;
         o_irq <= next_irq;
         o_lvd_comp_enable <= next_comp_enable;
         o_powerdown_enable <= next_pd_en;
         o_partial_powerdown_select <= next_ppd_out;
      end
   end

   assign o_detect_threshold_select = det_thr;
   assign o_warning_threshold_select = warn_thr;

endmodule

// >>> lvpm_top_assertions.sv
// Concurrent checks on the ports of the supply supervisor top.
// Assumes i_hready is fed back from o_hreadyout by the single bus master.
`timescale 1ns/10ps
`include "lvpm_cfg.svh"
module lvpm_top_chk import lvpm_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_por_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_stop_mode,
   input wire logic o_hreadyout,
   input wire logic [31:0] o_hrdata,
   input wire logic o_lvd_comp_enable,
   input wire logic o_detect_threshold_select,
   input wire logic o_warning_threshold_select,
   input wire logic o_lvd_irq,
   input wire logic o_lvd_reset_req,
   input wire logic o_powerdown_enable,
   input wire logic o_partial_powerdown_select
);
   // ---------------------------------------------------------------
   // Bus tracking
   // ---------------------------------------------------------------
   logic wr_ph;
   logic [7:0] wr_adr;
   logic warn_done;
   wire rst_n = i_rstn & i_por_rstn;
   wire taken = i_hsel & i_hready & i_htrans[1];
   wire rd_det = taken & !i_hwrite & (i_haddr[7:0] == `LVPM_OFS_DET);
   wire rd_warn = taken & !i_hwrite & (i_haddr[7:0] == `LVPM_OFS_WARN);
   wire warn_wr = wr_ph & i_hready & (wr_adr == `LVPM_OFS_WARN);

   // Tracks the first warning-control write, which alone may set the locks
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ph <= 1'h0;
         wr_adr <= 8'h00;
         warn_done <= 1'h0;
      end else if (i_hready) begin
         wr_ph <= taken & i_hwrite;
         wr_adr <= i_haddr[7:0];
         warn_done <= warn_done | warn_wr;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!rst_n);

   property p_rd_det;
      rd_det |=> !o_hreadyout ##1 (o_hreadyout && o_hrdata[6] == 1'h0);
   endproperty
   a_rd_det: assert property (p_rd_det)
      else $error("detect ack bit read back as one");

   property p_rd_warn;
      rd_warn |=> !o_hreadyout
         ##1 (o_hreadyout && o_hrdata[6] == 1'h0 && o_hrdata[2] == 1'h0);
   endproperty
   a_rd_warn: assert property (p_rd_warn)
      else $error("warning register ack bits read back as one");

   property p_sel_wr;
      warn_wr |=> o_detect_threshold_select == $past(i_hwdata[5])
         && o_warning_threshold_select == $past(i_hwdata[4]);
   endproperty
   a_sel_wr: assert property (p_sel_wr)
      else $error("threshold selects do not follow the write");

   property p_pd_first;
      warn_wr && !warn_done |=> o_powerdown_enable == $past(i_hwdata[1]);
   endproperty
   a_pd_first: assert property (p_pd_first)
      else $error("first write did not set power-down enable");

   property p_pd_lock;
      warn_wr && warn_done |=> $stable(o_powerdown_enable)
         && $stable(o_partial_powerdown_select);
   endproperty
   a_pd_lock: assert property (p_pd_lock)
      else $error("locked power-down bits changed");

   property p_ppd_gate;
      o_partial_powerdown_select |-> o_powerdown_enable;
   endproperty
   a_ppd_gate: assert property (p_ppd_gate)
      else $error("partial select active without power-down enable");

   property p_sel_keep;
      disable iff (!i_por_rstn) !i_rstn && $past(i_por_rstn)
         |-> $stable(o_detect_threshold_select)
         && $stable(o_warning_threshold_select);
   endproperty
   a_sel_keep: assert property (p_sel_keep)
      else $error("threshold selects lost in a non power-on reset");

   property p_det_off;
      !o_lvd_comp_enable && !i_stop_mode && !$past(i_stop_mode)
         |-> !o_lvd_irq && !o_lvd_reset_req;
   endproperty
   a_det_off: assert property (p_det_off)
      else $error("detect irq or reset with detection off");
endmodule

bind lvpm_top lvpm_top_chk i_lvpm_top_chk (.i_sys_clk, .i_rstn,
   .i_por_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
   .i_hready, .i_stop_mode, .o_hreadyout, .o_hrdata, .o_lvd_comp_enable,
   .o_detect_threshold_select, .o_warning_threshold_select, .o_lvd_irq,
   .o_lvd_reset_req, .o_powerdown_enable, .o_partial_powerdown_select);

// >>> lvpm_top_bench.sv
// Self-checking bench for the supply supervisor and power mode block.
// Assumes one AHB-Lite master; the slave's ready is the bus ready.
`timescale 1ns/10ps
`include "lvpm_cfg.svh"
module lvpm_top_bench;
   logic i_sys_clk = 1'h0;
   logic i_rstn = 1'h0;
   logic i_por_rstn = 1'h0;
   logic i_hsel = 1'h0;
   logic [31:0] i_haddr = 32'h0;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'h0;
   logic [31:0] i_hwdata = 32'h0;
   logic lvd_lo = 1'h0, lvd_hi = 1'h0, lvw_lo = 1'h0, lvw_hi = 1'h0;
   logic stop = 1'h0, rec = 1'h0;
   logic [31:0] rdat;
   wire o_hreadyout;
   wire [31:0] o_hrdata;
   wire hresp;
   // Bits: irq, comp enable, selects, lvd irq, reset, pd, ppd
   wire [7:0] outs;
   int errors = 0, n_compared = 0, cyc = 0;

   lvpm_top i_lvpm_top (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
      .i_por_rstn(i_por_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
      .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
      .o_hreadyout(o_hreadyout), .o_hresp(hresp), .o_hrdata(o_hrdata),
      .i_lvd_trip_low(lvd_lo), .i_lvd_trip_high(lvd_hi),
      .i_lvw_trip_low(lvw_lo), .i_lvw_trip_high(lvw_hi),
      .i_stop_mode(stop), .i_partial_powerdown_stop_exit(rec),
      .o_lvd_comp_enable(outs[6]), .o_detect_threshold_select(outs[5]),
      .o_warning_threshold_select(outs[4]), .o_lvd_irq(outs[3]),
      .o_lvd_reset_req(outs[2]), .o_powerdown_enable(outs[1]),
      .o_partial_powerdown_select(outs[0]), .o_irq(outs[7]));

   initial begin
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   // ---------------------------------------------------------------
   // Bus and check helpers
   // ---------------------------------------------------------------
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic pause(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   // Ready is looked at mid-cycle so the edge's own updates never race
   task automatic rdy;
      logic ok;
      do begin
         @(negedge i_sys_clk);
         ok = o_hreadyout;
         rdat = o_hrdata;
         @(posedge i_sys_clk);
      end while (ok !== 1'h1);
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input int d);
      i_hsel <= 1'h1;
      i_htrans <= 2'h2;
      i_haddr <= {24'h0, a};
      i_hwrite <= w;
      rdy;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      rdy;
   endtask

   task automatic wr(input logic [7:0] a, input int d);
      xfer(1'h1, a, d);
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a, e);
      xfer(1'h0, a, 0);
      chk(n, {24'h0, e}, rdat);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic ochk(input string n, input logic [7:0] e);
      @(negedge i_sys_clk);
      chk(n, {24'h0, e}, {24'h0, outs});
      @(posedge i_sys_clk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd_chk("det", `LVPM_OFS_DET, `LVPM_DET_RST);
      rd_chk("warn", `LVPM_OFS_WARN, `LVPM_WRN_RST);
      rd_chk("stat", `LVPM_OFS_STAT, 8'h00);
      rd_chk("mask", `LVPM_OFS_MASK, 8'h00);
      wr(8'h10, 32'hFF);
      rd_chk("unmapped", 8'h10, 8'h00);
      ochk("outs_reset", 8'h40);
   endtask

   task automatic t_power;
      wr(`LVPM_OFS_WARN, 32'h33);
      ochk("pd_first", 8'h73);
      wr(`LVPM_OFS_WARN, 32'h00);
      ochk("pd_locked", 8'h43);
      wr(`LVPM_OFS_WARN, 32'h31);
      ochk("sel_set", 8'h73);
      rd_chk("warn_rd", `LVPM_OFS_WARN, 8'h33);
   endtask

   task automatic t_detect;
      lvd_lo <= 1'h1;
      pause(6);
      ochk("low_trip", 8'h73);
      lvd_hi <= 1'h1;
      pause(6);
      ochk("det_rst", 8'h77);
      rd_chk("det_flag", `LVPM_OFS_DET, 8'h94);
      wr(`LVPM_OFS_DET, 32'h34);
      ochk("det_irq", 8'h7F);
      lvd_lo <= 1'h0;
      lvd_hi <= 1'h0;
      pause(6);
      ochk("det_held", 8'h7F);
      wr(`LVPM_OFS_DET, 32'h74);
      ochk("det_ack", 8'h73);
      rd_chk("det_clr", `LVPM_OFS_DET, 8'h34);
      rd_chk("stat_det", `LVPM_OFS_STAT, 8'h01);
      rd_chk("stat_clr", `LVPM_OFS_STAT, 8'h00);
      wr(`LVPM_OFS_DET, 32'h08);
      rd_chk("det_once", `LVPM_OFS_DET, 8'h14);
   endtask

   task automatic t_stop;
      stop <= 1'h1;
      pause(3);
      ochk("stop_off", 8'h33);
      stop <= 1'h0;
      pause(3);
      ochk("stop_on", 8'h73);
   endtask

   task automatic t_midreset;
      i_rstn <= 1'h0;
      pause(4);
      ochk("rst_keep", 8'h30);
      i_rstn <= 1'h1;
      pause(2);
      ochk("rst_out", 8'h70);
      rd_chk("warn_keep", `LVPM_OFS_WARN, 8'h30);
   endtask

   task automatic t_off;
      wr(`LVPM_OFS_DET, 32'h20);
      lvd_lo <= 1'h1;
      lvd_hi <= 1'h1;
      pause(6);
      ochk("det_off", 8'h30);
      rd_chk("det_off_flag", `LVPM_OFS_DET, 8'h20);
      lvd_lo <= 1'h0;
      lvd_hi <= 1'h0;
   endtask

   task automatic t_warn;
      wr(`LVPM_OFS_MASK, 32'h07);
      lvw_lo <= 1'h1;
      pause(6);
      ochk("lvw_low", 8'h30);
      lvw_hi <= 1'h1;
      pause(6);
      ochk("warn_irq", 8'hB0);
      wr(`LVPM_OFS_WARN, 32'h70);
      rd_chk("warn_held", `LVPM_OFS_WARN, 8'hB0);
      rd_chk("stat_warn", `LVPM_OFS_STAT, 8'h02);
      ochk("irq_clr", 8'h30);
      lvw_lo <= 1'h0;
      lvw_hi <= 1'h0;
      pause(6);
      wr(`LVPM_OFS_WARN, 32'h70);
      rd_chk("warn_ack", `LVPM_OFS_WARN, 8'h30);
   endtask

   task automatic t_ppd;
      rec <= 1'h1;
      pause(1);
      rec <= 1'h0;
      pause(2);
      ochk("ppd_irq", 8'hB0);
      rd_chk("ppd_flag", `LVPM_OFS_WARN, 8'h38);
      wr(`LVPM_OFS_WARN, 32'h34);
      rd_chk("ppd_ack", `LVPM_OFS_WARN, 8'h30);
      rd_chk("stat_ppd", `LVPM_OFS_STAT, 8'h04);
   endtask

   task automatic t_por;
      i_por_rstn <= 1'h0;
      pause(4);
      i_por_rstn <= 1'h1;
      pause(2);
      ochk("por_out", 8'h40);
      rd_chk("por_warn", `LVPM_OFS_WARN, 8'h00);
   endtask

   // Stop enable set: the detector must stay on through stop mode
   task automatic t_stop_keep;
      wr(`LVPM_OFS_DET, 32'h1C);
      stop <= 1'h1;
      pause(3);
      ochk("stop_keep", 8'h40);
      stop <= 1'h0;
   endtask

   // A hang is cut short well beyond the roughly 180 cycles needed
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         complete_run;
      end
   end

   initial begin
      pause(4);
      i_rstn <= 1'h1;
      i_por_rstn <= 1'h1;
      pause(1);
      t_reset;
      t_power;
      t_detect;
      t_stop;
      t_midreset;
      t_off;
      t_warn;
      t_ppd;
      t_por;
      t_stop_keep;
      complete_run;
   end
endmodule
